// >>> include/sta_cfg.svh
`ifndef STA_CFG_SVH
`define STA_CFG_SVH
`define STA_SOM 8'h1B
`define STA_CMD 8'h58
`define STA_BUF 8'h54
`define STA_INTER 8'h78
`define STA_EOB 8'h17
`define STA_RQ_ATT 8'h00
`define STA_RQ_RD 8'h01
`define STA_RQ_WR 8'h02
`define STA_RSP_BIT 8'h80
`define STA_SEG_WORD 8'h08
`define STA_MAX_DATA 17'h003E8
`define STA_INLINE_MAX 17'h00002
`define STA_BUF_OVH 17'h00008
`define STA_REQ_LAST 5'h17
`define STA_HEAD_ATT 5'h12
`define STA_HEAD_RSP 5'h09
`define STA_TAIL_LAST 5'h05
`define STA_ERR_MAJOR 8'h05
`define STA_ERR_LEN 8'h01
`define STA_ERR_BUF 8'h02
`define STA_ERR_CHK 8'h03
`define STA_BCC_SEED 8'h00
`define STA_B_ID 2
`define STA_B_CODE 10
`define STA_B_SEG 11
`define STA_B_OFF 12
`define STA_B_LEN 14
`define STA_B_DAT 16
`define STA_B_EOB 18
`define STA_B_NTYP 19
`define STA_B_NLEN 20
`endif

// >>> include/sta_pkg.sv
package sta_pkg;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_TYPE = 3'b001,
        RX_REQ = 3'b010,
        RX_BUFD = 3'b011,
        RX_BUFT = 3'b100,
        RX_WRITE = 3'b101,
        RX_REPLY = 3'b110
    } sta_rx_type;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_HEAD = 2'b01,
        TX_DATA = 2'b10,
        TX_TAIL = 2'b11
    } sta_tx_type;
    typedef enum logic [1:0] {
        RK_ATT = 2'b00,
        RK_RD = 2'b01,
        RK_WR = 2'b10,
        RK_INT = 2'b11
    } sta_kind_type;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [16:0] addr;
        logic [7:0] wdata;
    } sta_tbl_type;
    typedef struct packed {
        sta_rx_type st;
        sta_tx_type txp;
        sta_kind_type kind;
        logic session;
        logic expect_buf;
        logic bcast;
        logic from_buf;
        logic rx_ready;
        logic bad;
        logic [4:0] idx;
        logic [23:0][7:0] req;
        logic [7:0] bcc;
        logic [16:0] cnt;
        logic [16:0] nbytes;
        logic [7:0] major;
        logic [7:0] minor;
        logic [4:0] tidx;
        logic [7:0] tbcc;
        logic [1:0] rwait;
        sta_tbl_type tbl;
    } sta_state_type;
endpackage : sta_pkg

// >>> hw/sta_skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module sta_skid_buffer #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    // Two entries: the output stage and one skid stage, so a stall loses nothing.
    typedef struct packed {
        logic ov;
        logic [W-1:0] od;
        logic sv;
        logic [W-1:0] sd;
    } sta_buf_state_type;

    sta_buf_state_type s;
    sta_buf_state_type next_s;

    always_comb
    begin
        next_s = s;
        if (s.ov && out_ready)
        begin
            next_s.ov = s.sv;
            next_s.od = s.sd;
            next_s.sv = 1'b0;
        end
        if (in_valid && !s.sv)
        begin
            if (!next_s.ov)
            begin
                next_s.ov = 1'b1;
                next_s.od = in_data;
            end
            else
            begin
                next_s.sv = 1'b1;
                next_s.sd = in_data;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign in_ready = !s.sv;
    assign out_valid = s.ov;
    assign out_data = s.od;

    property p_hold;
        @(posedge clk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled byte changed");

    property p_accept;
        @(posedge clk) disable iff (rst)
        in_valid && in_ready && !out_valid |=> out_valid && out_data == $past(in_data);
    endproperty
    a_accept: assert property (p_accept) else $error("accepted byte not shown");
endmodule : sta_skid_buffer
`default_nettype wire

// >>> hw/sta_serial_table_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "sta_cfg.svh"

// Operation
// - Broadcast attach frame uses all-FF identifier, code 00h, fixed zero fields.
// - A read covers one contiguous region: selector, offset, length.
// - One read request yields exactly one reply frame of variable length.
// - Reads of up to 1000 data bytes are served.
// - A failed read still gets a reply carrying an error code.
// - Read bytes are byte-aligned; each bit keeps its own position.
// - Nothing addressed to all stations is ever answered.
// - On point-to-point, the null identifier counts as our own.
// - Read request: code 01h, selector, offset and length low byte first.
// - Selector 08h is word mode: length counts registers, two bytes each.
// - Read reply: 1Bh 58h 81h, status word, error bytes, count, data, trailer.
// - Writes of two bytes or fewer carry data inline, no continuation.
// - Longer writes take all data from the continuation; inline field ignored.
// - A directed write announcing continuation gets an intermediate response.
// - Continuation messages of up to 1000 data bytes are accepted.
// - Every directed write ends with a reply, with error code on failure.
// - Write bytes are byte-aligned; each bit at its own position.
// - Broadcast writes execute silently, intermediate response included.
// - Continuation: 1Bh 54h, data, 17h, zero type, length, spare, check.
// - Response code is the request code with the top bit set.
// - Write request code 02h; its reply code 82h.
// - Continuation announced by type 54h and length in bytes 21-22.
module sta_serial_table_slave #(
    parameter logic [16:0] MAX_DATA = `STA_MAX_DATA
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [63:0] STATION_ID,
    input wire logic POINT_TO_POINT,
    input wire logic LONG_BREAK,
    input wire logic [15:0] STATUS_WORD,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    output logic RX_READY,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic TX_READY,
    output logic TBL_RD,
    output logic TBL_WR,
    output logic [7:0] TBL_SEG,
    output logic [16:0] TBL_ADDR,
    output logic [7:0] TBL_WDATA,
    input wire logic [7:0] TBL_RDATA,
    output logic SESSION_ACTIVE
);
    localparam int AW = $clog2(int'(MAX_DATA));

    sta_pkg::sta_state_type s;
    sta_pkg::sta_state_type n;
    logic [7:0] mem [0:MAX_DATA-1];
    logic take, push_v, buf_rdy, disp, start;
    logic [7:0] push_d, hb, code, seg;
    logic [15:0] off, len, nlen;
    logic [16:0] nreq, rcnt;
    logic [63:0] id_rx;
    logic [4:0] tsub, hlast;
    logic word_mode, id_bc, id_mine, len_ok, chk_ok;
    sta_pkg::sta_kind_type kind_v;

    function automatic logic [7:0] bcc_step(input logic [7:0] c, input logic [7:0] b);
        return {c[6:0], c[7]} ^ b;
    endfunction : bcc_step

    function automatic logic [16:0] byte_addr(input logic [16:0] k);
        logic [16:0] base;
        base = word_mode ? {off, 1'b0} : {1'b0, off};
        return base + k;
    endfunction : byte_addr

    for (genvar g = 0; g < 8; g++)
    begin : g_id
        assign id_rx[8*g +: 8] = s.req[`STA_B_ID + g];
    end

    assign take = RX_VALID && s.rx_ready;
    assign code = s.req[`STA_B_CODE];
    assign seg = s.req[`STA_B_SEG];
    assign off = {s.req[`STA_B_OFF + 1], s.req[`STA_B_OFF]};
    assign len = {s.req[`STA_B_LEN + 1], s.req[`STA_B_LEN]};
    assign nlen = {s.req[`STA_B_NLEN + 1], s.req[`STA_B_NLEN]};
    assign word_mode = seg == `STA_SEG_WORD;
    assign nreq = word_mode ? {len, 1'b0} : {1'b0, len};
    assign len_ok = nreq != 17'h00000 && nreq <= MAX_DATA;
    assign id_bc = &id_rx;
    assign id_mine = !id_bc && (id_rx == STATION_ID || (POINT_TO_POINT && id_rx == 64'h0));
    assign chk_ok = RX_DATA == s.bcc;
    assign rcnt = (s.kind == sta_pkg::RK_RD && s.major == 8'h00) ? s.nbytes : 17'h00000;
    assign tsub = s.tidx - 5'h02;
    assign hlast = (s.kind == sta_pkg::RK_ATT) ? `STA_HEAD_ATT - 5'h01 : `STA_HEAD_RSP - 5'h01;

    // Header byte of the reply being sent; response codes carry the top bit.
    always_comb
    begin
        hb = 8'h00;
        if (s.tidx == 5'h00)
            hb = `STA_SOM;
        else if (s.tidx == 5'h01)
            hb = (s.kind == sta_pkg::RK_INT) ? `STA_INTER : `STA_CMD;
        else if (s.kind == sta_pkg::RK_ATT)
        begin
            if (s.tidx < 5'h0A)
                hb = STATION_ID[{tsub[2:0], 3'b000} +: 8];
            else if (s.tidx == 5'h0A)
                hb = `STA_RQ_ATT | `STA_RSP_BIT;
        end
        else if (s.tidx == 5'h02)
            hb = ((s.kind == sta_pkg::RK_RD) ? `STA_RQ_RD : `STA_RQ_WR) | `STA_RSP_BIT;
        else if (s.kind != sta_pkg::RK_INT)
        begin
            unique case (s.tidx)
                5'h03: hb = STATUS_WORD[7:0];
                5'h04: hb = STATUS_WORD[15:8];
                5'h05: hb = s.major;
                5'h06: hb = s.minor;
                5'h07: hb = rcnt[7:0];
                5'h08: hb = rcnt[15:8];
                default: hb = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        n = s;
        n.tbl.rd = 1'b0;
        n.tbl.wr = 1'b0;
        push_v = 1'b0;
        push_d = 8'h00;
        disp = 1'b0;
        start = 1'b0;
        kind_v = sta_pkg::RK_WR;

        unique case (s.txp)
            sta_pkg::TX_IDLE: ;
            sta_pkg::TX_HEAD:
            begin
                push_v = 1'b1;
                push_d = hb;
                if (buf_rdy)
                begin
                    n.tbcc = bcc_step(s.tbcc, hb);
                    n.tidx = s.tidx + 5'h01;
                    if (s.tidx == hlast)
                    begin
                        n.tidx = 5'h00;
                        n.txp = (rcnt != 17'h00000) ? sta_pkg::TX_DATA : sta_pkg::TX_TAIL;
                    end
                end
            end
            sta_pkg::TX_DATA:
            begin
                // One table read per byte; the buffer slot seen free at issue
                // stays free, since nothing else is pushed while we wait.
                if (s.rwait == 2'b00)
                begin
                    if (buf_rdy)
                    begin
                        n.tbl.rd = 1'b1;
                        n.tbl.addr = byte_addr(s.cnt);
                        n.rwait = 2'b01;
                    end
                end
                else if (s.rwait == 2'b01)
                    n.rwait = 2'b10;
                else
                begin
                    push_v = 1'b1;
                    push_d = TBL_RDATA;
                    n.tbcc = bcc_step(s.tbcc, TBL_RDATA);
                    n.cnt = s.cnt + 17'h00001;
                    n.rwait = 2'b00;
                    if (n.cnt == s.nbytes)
                        n.txp = sta_pkg::TX_TAIL;
                end
            end
            sta_pkg::TX_TAIL:
            begin
                push_v = 1'b1;
                push_d = (s.tidx == 5'h00) ? `STA_EOB : 8'h00;
                if (s.tidx == `STA_TAIL_LAST)
                    push_d = s.tbcc;
                if (buf_rdy)
                begin
                    n.tbcc = bcc_step(s.tbcc, push_d);
                    n.tidx = s.tidx + 5'h01;
                    if (s.tidx == `STA_TAIL_LAST)
                        n.txp = sta_pkg::TX_IDLE;
                end
            end
        endcase

        unique case (s.st)
            sta_pkg::RX_IDLE:
                if (take && RX_DATA == `STA_SOM)
                begin
                    n.st = sta_pkg::RX_TYPE;
                    n.bcc = bcc_step(`STA_BCC_SEED, RX_DATA);
                end
            sta_pkg::RX_TYPE:
                if (take)
                begin
                    n.bcc = bcc_step(s.bcc, RX_DATA);
                    n.st = sta_pkg::RX_IDLE;
                    n.cnt = 17'h00000;
                    n.bad = 1'b0;
                    if (RX_DATA == `STA_CMD)
                    begin
                        n.st = sta_pkg::RX_REQ;
                        n.idx = 5'h02;
                    end
                    else if (RX_DATA == `STA_BUF && s.expect_buf)
                        n.st = sta_pkg::RX_BUFD;
                end
            sta_pkg::RX_REQ:
                if (take)
                begin
                    n.req[s.idx] = RX_DATA;
                    n.bcc = bcc_step(s.bcc, RX_DATA);
                    n.idx = s.idx + 5'h01;
                    if (s.idx == `STA_REQ_LAST)
                    begin
                        n.st = sta_pkg::RX_IDLE;
                        disp = chk_ok && s.req[`STA_B_EOB] == `STA_EOB;
                    end
                end
            sta_pkg::RX_BUFD:
                if (take)
                begin
                    n.bcc = bcc_step(s.bcc, RX_DATA);
                    n.cnt = s.cnt + 17'h00001;
                    if (n.cnt == s.nbytes)
                    begin
                        n.st = sta_pkg::RX_BUFT;
                        n.idx = 5'h00;
                    end
                end
            sta_pkg::RX_BUFT:
                if (take)
                begin
                    n.bcc = bcc_step(s.bcc, RX_DATA);
                    n.idx = s.idx + 5'h01;
                    if (s.idx != `STA_TAIL_LAST)
                        n.bad = s.bad || RX_DATA != ((s.idx == 5'h00) ? `STA_EOB : 8'h00);
                    else
                    begin
                        n.expect_buf = 1'b0;
                        n.cnt = 17'h00000;
                        n.st = sta_pkg::RX_IDLE;
                        if (chk_ok && !s.bad)
                        begin
                            n.st = sta_pkg::RX_WRITE;
                            n.from_buf = 1'b1;
                        end
                        else if (!s.bcast)
                        begin
                            start = 1'b1;
                            n.major = `STA_ERR_MAJOR;
                            n.minor = `STA_ERR_CHK;
                        end
                    end
                end
            sta_pkg::RX_WRITE:
            begin
                n.tbl.wr = 1'b1;
                n.tbl.addr = byte_addr(s.cnt);
                n.tbl.wdata = s.from_buf ? mem[s.cnt[AW-1:0]] : s.req[`STA_B_DAT + int'(s.cnt[0])];
                n.cnt = s.cnt + 17'h00001;
                if (n.cnt == s.nbytes)
                begin
                    n.st = sta_pkg::RX_IDLE;
                    start = !s.bcast;
                end
            end
            sta_pkg::RX_REPLY:
                if (s.txp == sta_pkg::TX_IDLE)
                    n.st = sta_pkg::RX_IDLE;
            default: n.st = sta_pkg::RX_IDLE;
        endcase

        if (LONG_BREAK)
        begin
            // A long break ends the session, but an attach landing in the same cycle wins.
            // A reply already under way still completes.
            n.session = 1'b0;
            n.expect_buf = 1'b0;
        end
        if (disp)
        begin
            n.expect_buf = 1'b0;
            n.major = 8'h00;
            n.minor = 8'h00;
            n.nbytes = nreq;
            n.cnt = 17'h00000;
            n.bcast = id_bc;
            if (code == `STA_RQ_ATT && (id_bc || id_mine))
            begin
                n.session = 1'b1;
                start = id_mine;
                kind_v = sta_pkg::RK_ATT;
            end
            else if (s.session && code == `STA_RQ_RD && id_mine)
            begin
                start = 1'b1;
                kind_v = sta_pkg::RK_RD;
                if (!len_ok)
                begin
                    n.major = `STA_ERR_MAJOR;
                    n.minor = `STA_ERR_LEN;
                end
            end
            else if (s.session && code == `STA_RQ_WR && (id_mine || id_bc))
            begin
                start = !id_bc;
                if (s.req[`STA_B_NTYP] == `STA_BUF)
                begin
                    if (len_ok && nreq > `STA_INLINE_MAX && {1'b0, nlen} == nreq + `STA_BUF_OVH)
                    begin
                        n.expect_buf = 1'b1;
                        kind_v = sta_pkg::RK_INT;
                    end
                    else
                    begin
                        n.major = `STA_ERR_MAJOR;
                        n.minor = `STA_ERR_BUF;
                    end
                end
                else if (len_ok && nreq <= `STA_INLINE_MAX)
                begin
                    start = 1'b0;
                    n.st = sta_pkg::RX_WRITE;
                    n.from_buf = 1'b0;
                end
                else
                begin
                    n.major = `STA_ERR_MAJOR;
                    n.minor = `STA_ERR_LEN;
                end
            end
        end

        if (start)
        begin
            n.st = sta_pkg::RX_REPLY;
            n.txp = sta_pkg::TX_HEAD;
            n.kind = (s.st == sta_pkg::RX_REQ) ? kind_v : sta_pkg::RK_WR;
            n.tidx = 5'h00;
            n.tbcc = `STA_BCC_SEED;
            n.rwait = 2'b00;
        end
        if (disp)
            n.tbl.addr = 17'h00000;
        n.rx_ready = n.st inside {sta_pkg::RX_IDLE, sta_pkg::RX_TYPE, sta_pkg::RX_REQ,
                                  sta_pkg::RX_BUFD, sta_pkg::RX_BUFT};
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            s <= '0;
        else
            s <= n;
    end

    // Continuation data is held until its check code passes, so a bad frame writes nothing.
    always_ff @(posedge REF_CLK)
    begin
        if (s.st == sta_pkg::RX_BUFD && take)
            mem[s.cnt[AW-1:0]] <= RX_DATA;
    end

    sta_skid_buffer #(.W(8)) u_txbuf (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .in_valid(push_v),
        .in_data(push_d),
        .in_ready(buf_rdy),
        .out_valid(TX_VALID),
        .out_data(TX_DATA),
        .out_ready(TX_READY)
    );

    assign RX_READY = s.rx_ready;
    assign TBL_RD = s.tbl.rd;
    assign TBL_WR = s.tbl.wr;
    assign TBL_SEG = s.req[`STA_B_SEG];
    assign TBL_ADDR = s.tbl.addr;
    assign TBL_WDATA = s.tbl.wdata;
    assign SESSION_ACTIVE = s.session;

    property p_bc_silent;
        @(posedge REF_CLK) disable iff (SYS_RST)
        disp && id_bc |=> s.txp == sta_pkg::TX_IDLE;
    endproperty
    a_bc_silent: assert property (p_bc_silent) else $error("broadcast answered");

    property p_no_session;
        @(posedge REF_CLK) disable iff (SYS_RST)
        disp && !s.session && code != `STA_RQ_ATT |=> s.txp == sta_pkg::TX_IDLE && !TBL_WR;
    endproperty
    a_no_session: assert property (p_no_session) else $error("command outside session");

    property p_bad_check;
        @(posedge REF_CLK) disable iff (SYS_RST)
        take && s.st == sta_pkg::RX_REQ && s.idx == `STA_REQ_LAST && !chk_ok
        |=> s.txp == sta_pkg::TX_IDLE [*2];
    endproperty
    a_bad_check: assert property (p_bad_check) else $error("bad check code accepted");

    property p_inline;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s.st == sta_pkg::RX_WRITE && !s.from_buf |-> s.nbytes <= `STA_INLINE_MAX;
    endproperty
    a_inline: assert property (p_inline) else $error("inline write too long");

    property p_buf_max;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s.st == sta_pkg::RX_WRITE |-> s.nbytes <= MAX_DATA && s.nbytes != 17'h00000;
    endproperty
    a_buf_max: assert property (p_buf_max) else $error("write length out of range");

    property p_read_ok;
        @(posedge REF_CLK) disable iff (SYS_RST)
        s.txp == sta_pkg::TX_DATA |-> s.major == 8'h00 && s.nbytes <= MAX_DATA;
    endproperty
    a_read_ok: assert property (p_read_ok) else $error("data sent with error");

    property p_rsp_code;
        @(posedge REF_CLK) disable iff (SYS_RST)
        push_v && s.txp == sta_pkg::TX_HEAD && s.tidx == 5'h02 && s.kind != sta_pkg::RK_ATT
        |-> push_d[7] && push_d[6:0] != 7'h00;
    endproperty
    a_rsp_code: assert property (p_rsp_code) else $error("response code lacks top bit");

    property p_rd_data;
        @(posedge REF_CLK) disable iff (SYS_RST)
        TBL_RD |-> ##1 push_v && push_d == TBL_RDATA && buf_rdy;
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read byte not forwarded");

    property p_frame_start;
        @(posedge REF_CLK) disable iff (SYS_RST)
        start |=> push_v && push_d == `STA_SOM;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("reply not opened");
endmodule : sta_serial_table_slave
`default_nettype wire

// >>> tb/sta_link_master.sv
`timescale 1ns/1ps
`default_nettype none
module sta_link_master (
    input wire logic clk,
    output logic tx_ready
);
    int seed = 53;
    initial tx_ready = 1'b0;
    // Random stalls make the output buffer hold bytes across busy cycles.
    always @(negedge clk)
    begin
        tx_ready <= ($random(seed) % 3) != 0;
    end
endmodule : sta_link_master
`default_nettype wire

// >>> tb/serial_table_access_slave_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_table_access_slave_test;
    logic REF_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic POINT_TO_POINT = 1'b0;
    logic RX_VALID = 1'b0;
    logic [7:0] RX_DATA = 8'h00;
    logic [63:0] STATION_ID;
    logic [15:0] STATUS_WORD;
    logic RX_READY, TX_VALID, TX_READY, TBL_RD, TBL_WR, SESSION_ACTIVE;
    logic [7:0] TX_DATA, TBL_SEG, TBL_WDATA, TBL_RDATA, v, sel;
    logic [7:0] bad = 8'h00;
    logic LONG_BREAK = 1'b0;
    logic [16:0] TBL_ADDR;
    logic [7:0] mem [256];
    logic [7:0] shadow [256];
    logic [7:0] exp_q [$];
    logic [7:0] f [$];
    int seed = 53;
    int error_cnt = 0;
    int num_checks = 0;
    always #20 REF_CLK = ~REF_CLK;
    sta_link_master sta_link_master_inst (.clk(REF_CLK), .tx_ready(TX_READY));
    sta_serial_table_slave sta_serial_table_slave_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
        .STATION_ID(STATION_ID), .POINT_TO_POINT(POINT_TO_POINT), .LONG_BREAK(LONG_BREAK),
        .STATUS_WORD(STATUS_WORD), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
        .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
        .TBL_RD(TBL_RD), .TBL_WR(TBL_WR), .TBL_SEG(TBL_SEG), .TBL_ADDR(TBL_ADDR),
        .TBL_WDATA(TBL_WDATA), .TBL_RDATA(TBL_RDATA), .SESSION_ACTIVE(SESSION_ACTIVE));
    always @(posedge REF_CLK)
    begin
        if (TBL_WR === 1'b1) mem[TBL_ADDR[7:0]] <= TBL_WDATA;
        if (TBL_RD === 1'b1) TBL_RDATA <= mem[TBL_ADDR[7:0]];
        if ((TBL_RD | TBL_WR) === 1'b1)
        begin
            num_checks++;
            if (TBL_SEG !== sel) note("table segment");
        end
        if (TX_VALID === 1'b1 && TX_READY)
        begin
            num_checks++;
            if (exp_q.size() == 0 || exp_q.pop_front() !== TX_DATA) note("reply byte");
        end
    end
    task automatic note(input string m);
        error_cnt++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask : note
    task automatic conclude(input bit hung);
        if (hung) note("wait ran out");
        $display("errors=%0d checks=%0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    function automatic logic [7:0] bcc(input logic [7:0] q [$]);
        logic [7:0] c;
        c = 8'h00;
        foreach (q[i]) c = {c[6:0], c[7]} ^ q[i];
        return c;
    endfunction : bcc
    task automatic send();
        f.push_back(bcc(f) ^ bad);
        foreach (f[i])
        begin
            @(negedge REF_CLK);
            RX_VALID = 1'b1;
            RX_DATA = f[i];
            for (int n = 0; RX_READY !== 1'b1; n++)
            begin
                if (n > 9000) conclude(1);
                @(negedge REF_CLK);
            end
            @(posedge REF_CLK);
        end
        @(negedge REF_CLK);
        RX_VALID = 1'b0;
        if (f[1] == 8'h58) sel = f[11];
        f.delete();
    endtask : send
    task automatic req(input logic [63:0] id, input logic [7:0] code, seg,
        input logic [15:0] off, len, dat, input logic [7:0] nt, input logic [15:0] nl);
        f = {8'h1B, 8'h58};
        for (int k = 0; k < 8; k++) f.push_back(id[8*k +: 8]);
        f = {f, code, seg, off[7:0], off[15:8], len[7:0], len[15:8], dat[7:0], dat[15:8],
            8'h17, nt, nl[7:0], nl[15:8], 8'h00};
        send();
    endtask : req
    task automatic fin(input logic [7:0] r [$]);
        r = {r, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00};
        exp_q = {exp_q, r, bcc(r)};
    endtask : fin
    task automatic rsp(input logic [7:0] code, minor, input logic [15:0] n, input logic [7:0] a);
        logic [7:0] r [$];
        r = {8'h1B, 8'h58, code, STATUS_WORD[7:0], STATUS_WORD[15:8],
            (minor != 8'h00) ? 8'h05 : 8'h00, minor, n[7:0], n[15:8]};
        for (int k = 0; k < n; k++) r.push_back(shadow[8'(a + k)]);
        fin(r);
    endtask : rsp
    task automatic idle();
        for (int n = 0; exp_q.size() != 0 || RX_READY !== 1'b1; n++)
        begin
            if (n > 9000) conclude(1);
            @(negedge REF_CLK);
        end
        repeat (40) @(negedge REF_CLK);
    endtask : idle
    initial
    begin
        STATION_ID = {$random(seed), $random(seed)};
        STATUS_WORD = 16'($random(seed));
        foreach (mem[i]) mem[i] = 8'($random(seed));
        foreach (mem[i]) shadow[i] = mem[i];
        repeat (6) @(negedge REF_CLK);
        SYS_RST = 1'b0;
        req(STATION_ID, 8'h01, 8'h08, 16'h0000, 16'h0004, 16'h0000, 8'h00, 16'h0000);
        idle();
        req('1, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000, 8'h00, 16'h0000);
        idle();
        num_checks++;
        if (SESSION_ACTIVE !== 1'b1) note("session not opened");
        f = {8'h1B, 8'h58};
        for (int k = 0; k < 8; k++) f.push_back(STATION_ID[8*k +: 8]);
        fin({f, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        req(STATION_ID, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000, 8'h00, 16'h0000);
        rsp(8'h81, 8'h00, 16'h0008, 8'h00);
        req(STATION_ID, 8'h01, 8'h08, 16'h0000, 16'h0004, 16'h0000, 8'h00, 16'h0000);
        req('1, 8'h01, 8'h08, 16'h0000, 16'h0004, 16'h0000, 8'h00, 16'h0000);
        idle();
        POINT_TO_POINT = 1'b1;
        rsp(8'h81, 8'h00, 16'h0003, 8'h40);
        req('0, 8'h01, 8'h10, 16'h0040, 16'h0003, 16'h0000, 8'h00, 16'h0000);
        POINT_TO_POINT = 1'b0;
        rsp(8'h81, 8'h01, 16'h0000, 8'h00);
        req(STATION_ID, 8'h01, 8'h08, 16'h0000, 16'h0000, 16'h0000, 8'h00, 16'h0000);
        rsp(8'h81, 8'h01, 16'h0000, 8'h00);
        req(STATION_ID, 8'h01, 8'h08, 16'h0000, 16'h01F5, 16'h0000, 8'h00, 16'h0000);
        rsp(8'h81, 8'h00, 16'h03E8, 8'h00);
        req(STATION_ID, 8'h01, 8'h08, 16'h0000, 16'h01F4, 16'h0000, 8'h00, 16'h0000);
        idle();
        v = 8'($random(seed));
        shadow[8'h20] = v;
        rsp(8'h82, 8'h00, 16'h0000, 8'h00);
        req(STATION_ID, 8'h02, 8'h10, 16'h0020, 16'h0001, {8'h00, v}, 8'h00, 16'h0000);
        shadow[8'h60] = 8'h5A;
        shadow[8'h61] = 8'hC3;
        req('1, 8'h02, 8'h08, 16'h0030, 16'h0001, 16'hC35A, 8'h00, 16'h0000);
        idle();
        fin({8'h1B, 8'h78, 8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        req(STATION_ID, 8'h02, 8'h10, 16'h0080, 16'h0004, 16'hFFFF, 8'h54, 16'h000C);
        idle();
        f = {8'h1B, 8'h54};
        for (int k = 0; k < 4; k++)
        begin
            shadow[8'h80 + k] = 8'($random(seed));
            f.push_back(shadow[8'h80 + k]);
        end
        f = {f, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00};
        rsp(8'h82, 8'h00, 16'h0000, 8'h00);
        send();
        rsp(8'h81, 8'h00, 16'h0064, 8'h20);
        req(STATION_ID, 8'h01, 8'h10, 16'h0020, 16'h0064, 16'h0000, 8'h00, 16'h0000);
        idle();
        bad = 8'h01;
        req(STATION_ID, 8'h01, 8'h08, 16'h0000, 16'h0004, 16'h0000, 8'h00, 16'h0000);
        bad = 8'h00;
        idle();
        LONG_BREAK = 1'b1;
        @(negedge REF_CLK);
        LONG_BREAK = 1'b0;
        req(STATION_ID, 8'h01, 8'h08, 16'h0000, 16'h0004, 16'h0000, 8'h00, 16'h0000);
        idle();
        num_checks++;
        if (SESSION_ACTIVE !== 1'b0) note("session not closed");
        conclude(0);
    end
endmodule : serial_table_access_slave_test
`default_nettype wire
